// ### verilog/tear_scanline_cmds.sv
`timescale 1ns/1ps
`include "tear_defs.svh"

// How it works
// - Command 44h plus byte sets line, enables output
// - Output asserts when scan reaches stored line
// - Pulse at gate value plus two minus porch
// - Output held low during sleep
// - Command 45h read returns stored line value
// - D3h: dummy, then three customer bytes
// - DAh: dummy, then module maker byte
// - Identity bytes come from rewritable store
// - All four commands work in every state
module tear_scanline_cmds (
	// Clock, reset, enable
	input  wire logic                    CLK_IN,
	input  wire logic                    RST_IN,
	input  wire logic                    CE_IN,
	// Host bus pins (asynchronous)
	input  wire tear_pkg::host_bus_type  HOST_IN,
	output logic [7:0]                   DATA_OUT,
	output logic                         DATA_OE_OUT,
	// Scan timing from the panel timing generator
	input  wire tear_pkg::scan_info_type SCAN_IN,
	// Identity store programming
	input  wire tear_pkg::id_prog_type   ID_PROG_IN,
	// Tearing-effect pin
	output logic                         TEAR_SYNC_OUT
);

	// ****************************************
	// Declarations
	// ****************************************
	tear_pkg::host_bus_type  meta_q;        // First synchroniser stage
	tear_pkg::host_bus_type  sync_q;        // Second synchroniser stage
	tear_pkg::host_bus_type  prev_q;        // Previous synced sample
	logic                    wr_rise;       // Write strobe rising edge
	logic                    rd_rise;       // Read strobe rising edge
	logic                    rd_fall;       // Read strobe falling edge

	tear_pkg::cmd_state_type state_q;       // Decoder state
	tear_pkg::cmd_state_type state_d;
	logic [7:0]              cmd_q;         // Command being served
	logic [7:0]              cmd_d;
	logic [2:0]              slot_q;        // Read slots done
	logic [2:0]              slot_d;
	logic [7:0]              tear_line_value_q; // Stored scan line
	logic [7:0]              tear_line_value_d;
	logic                    tear_enable_q; // Tear output switched on
	logic                    tear_enable_d;
	logic [7:0]              data_d;
	logic                    oe_d;
	logic                    tear_d;

	logic [1:0]              id_addr;       // Store word to read
	logic [7:0]              id_rdata;      // Store word, registered
	logic [9:0]              tear_target;   // Gate position of the pulse
	logic                    line_match;    // Current line is the target

	// ****************************************
	// Store address for a command and slot
	// ****************************************
	function automatic logic [1:0] slot_addr(input logic [7:0] cmd, input logic [2:0] slot);
		if (cmd == `CMD_MAKER_ID) begin
			slot_addr = `ID_ADDR_MAKER;
		end else begin
			// Slot 1 is the first customer byte; slot 0 is the dummy
			slot_addr = 2'(slot - 3'h1);
		end
	endfunction

	// ****************************************
	// Whether a read slot is valid for a command
	// ****************************************
	function automatic logic slot_valid(input logic [7:0] cmd, input logic [2:0] slot);
		if (cmd == `CMD_CUSTOMER_ID) begin
			slot_valid = (slot < `CUSTOMER_ID_SLOTS);
		end else if (cmd == `CMD_MAKER_ID) begin
			slot_valid = (slot < `MAKER_ID_SLOTS);
		end else begin
			slot_valid = (slot == 3'h0);
		end
	endfunction

	// ****************************************
	// Pin synchroniser; the first stage is never looked at
	// ****************************************
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			meta_q <= '{command_data_select: 1'b1, write_strobe: 1'b1,
				read_strobe: 1'b1, data: 8'h00};
			sync_q <= '{command_data_select: 1'b1, write_strobe: 1'b1,
				read_strobe: 1'b1, data: 8'h00};
			prev_q <= '{command_data_select: 1'b1, write_strobe: 1'b1,
				read_strobe: 1'b1, data: 8'h00};
		end else if (CE_IN) begin
			meta_q <= HOST_IN;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Strobe edges, from synced samples only
	assign wr_rise = sync_q.write_strobe & ~prev_q.write_strobe;
	assign rd_rise = sync_q.read_strobe & ~prev_q.read_strobe;
	assign rd_fall = ~sync_q.read_strobe & prev_q.read_strobe;

	// ****************************************
	// Identity store
	// ****************************************
	assign id_addr = slot_addr(cmd_q, slot_q);

	id_store u_id_store (
		.clk_in    (CLK_IN),
		.rst_in    (RST_IN),
		.ce_in     (CE_IN),
		.prog_in   (ID_PROG_IN),
		.raddr_in  (id_addr),
		.rdata_out (id_rdata)
	);

	// ****************************************
	// Command decoder next state
	// ****************************************
	// No sleep or display-mode term gates this decoder, on purpose
	always_comb begin
		state_d           = state_q;
		cmd_d             = cmd_q;
		slot_d            = slot_q;
		tear_line_value_d = tear_line_value_q;
		tear_enable_d     = tear_enable_q;
		data_d            = DATA_OUT;
		oe_d              = DATA_OE_OUT;
		if (wr_rise && !sync_q.command_data_select) begin
			// A command byte always restarts the decoder
			cmd_d  = sync_q.data;
			slot_d = 3'h0;
			unique case (sync_q.data)
				`CMD_TEAR_LINE_SET: begin
					state_d = tear_pkg::ST_WAIT_PARAM;
				end
				`CMD_TEAR_LINE_GET, `CMD_CUSTOMER_ID, `CMD_MAKER_ID: begin
					state_d = tear_pkg::ST_READ;
				end
				default: begin
					// Other commands belong to other blocks
					state_d = tear_pkg::ST_IDLE;
				end
			endcase
		end else begin
			unique case (state_q)
				tear_pkg::ST_IDLE: begin
					oe_d = 1'b0;
				end
				tear_pkg::ST_WAIT_PARAM: begin
					if (wr_rise) begin
						tear_line_value_d = sync_q.data;
						tear_enable_d     = 1'b1;
						state_d           = tear_pkg::ST_IDLE;
					end
				end
				tear_pkg::ST_READ: begin
					if (rd_fall) begin
						oe_d = 1'b1;
						if (!slot_valid(cmd_q, slot_q)) begin
							// Extra reads past the last byte return zero
							data_d = `DUMMY_BYTE;
						end else if (cmd_q == `CMD_TEAR_LINE_GET) begin
							data_d = tear_line_value_q;
						end else if (slot_q == 3'h0) begin
							data_d = `DUMMY_BYTE;
						end else begin
							data_d = id_rdata;
						end
					end else if (rd_rise) begin
						oe_d = 1'b0;
						// Stay here until the next command so extra reads give zero;
						// count stops at the end so it never wraps back onto data
						if (slot_valid(cmd_q, slot_q)) begin
							slot_d = slot_q + 3'h1;
						end
					end
				end
				default: begin
					state_d = tear_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Command decoder registers
	// ****************************************
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q           <= tear_pkg::ST_IDLE;
			cmd_q             <= 8'h00;
			slot_q            <= 3'h0;
			tear_line_value_q <= `TEAR_LINE_RESET;
			tear_enable_q     <= 1'b0;
			DATA_OUT          <= 8'h00;
			DATA_OE_OUT       <= 1'b0;
		end else if (CE_IN) begin
			state_q           <= state_d;
			cmd_q             <= cmd_d;
			slot_q            <= slot_d;
			tear_line_value_q <= tear_line_value_d;
			tear_enable_q     <= tear_enable_d;
			DATA_OUT          <= data_d;
			DATA_OE_OUT       <= oe_d;
		end
	end

	// ****************************************
	// Tear pulse placement
	// ****************************************
	// Target goes negative for short values; bit 9 then blocks a match
	assign tear_target = {2'b00, tear_line_value_q} + `TEAR_GATE_OFFSET
		- {2'b00, SCAN_IN.back_porch_lines};
	assign line_match = !tear_target[9]
		&& (tear_target[8:0] == {1'b0, SCAN_IN.gate_line_index});

	// ****************************************
	// Tear output next value
	// ****************************************
	always_comb begin
		if (SCAN_IN.sleep_mode || !tear_enable_q) begin
			tear_d = 1'b0;
		end else if (SCAN_IN.line_start) begin
			// Pulse lasts exactly one gate line
			tear_d = line_match;
		end else begin
			tear_d = TEAR_SYNC_OUT;
		end
	end

	// ****************************************
	// Tear output register
	// ****************************************
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			TEAR_SYNC_OUT <= 1'b0;
		end else if (CE_IN) begin
			TEAR_SYNC_OUT <= tear_d;
		end
	end

endmodule

// ### verilog/tear_defs.svh
`ifndef TEAR_DEFS_SVH
`define TEAR_DEFS_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_TEAR_LINE_SET   8'h44
`define CMD_TEAR_LINE_GET   8'h45
`define CMD_CUSTOMER_ID     8'hd3
`define CMD_MAKER_ID        8'hda

// ****************************************
// Reset values and fixed values
// ****************************************
`define TEAR_LINE_RESET     8'h00
`define DUMMY_BYTE          8'h00
`define TEAR_GATE_OFFSET    10'h002
// Arbitrary factory contents of the identity store
`define CUSTOMER_ID_RESET   24'h3c5a7e
`define MAKER_ID_RESET      8'ha5

// ****************************************
// Identity store word addresses
// ****************************************
`define ID_ADDR_CUSTOMER_1  2'h0
`define ID_ADDR_CUSTOMER_2  2'h1
`define ID_ADDR_CUSTOMER_3  2'h2
`define ID_ADDR_MAKER       2'h3

// ****************************************
// Read slot counts per command
// ****************************************
`define CUSTOMER_ID_SLOTS   3'h4
`define MAKER_ID_SLOTS      3'h2

`endif

// ### verilog/tear_pkg.sv
package tear_pkg;

	// ****************************************
	// Host bus pin group
	// ****************************************
	typedef struct packed {
		logic       command_data_select; // Low for command, high for parameter
		logic       write_strobe;        // Capture on rising edge
		logic       read_strobe;         // Drive while low, advance on rise
		logic [7:0] data;                // Byte from host
	} host_bus_type;

	// ****************************************
	// Panel scan timing group
	// ****************************************
	typedef struct packed {
		logic       line_start;       // One-cycle pulse at each new gate line
		logic [7:0] gate_line_index;  // Gate line now scanned
		logic [7:0] back_porch_lines; // Back porch length in lines
		logic       sleep_mode;       // Panel asleep
	} scan_info_type;

	// ****************************************
	// Identity store programming group
	// ****************************************
	typedef struct packed {
		logic       write;
		logic [1:0] addr;
		logic [7:0] data;
	} id_prog_type;

	// ****************************************
	// Command decoder states
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_WAIT_PARAM = 2'b01,
		ST_READ       = 2'b10
	} cmd_state_type;

endpackage

// ### verilog/id_store.sv
`timescale 1ns/1ps
`include "tear_defs.svh"

// Rewritable nonvolatile identity bytes, four words, registered read
module id_store (
	// Clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               ce_in,
	// Programming side
	input  wire tear_pkg::id_prog_type prog_in,
	// Read side
	input  wire logic [1:0]         raddr_in,
	output logic      [7:0]         rdata_out
);

	logic [7:0] mem_q [4];  // Stored bytes
	logic [7:0] mem_d [4];  // Next stored bytes
	logic [7:0] rdata_d;    // Next read word

	// Factory customer bytes, one in the top byte
	localparam logic [23:0] customer_reset = `CUSTOMER_ID_RESET;

	// ****************************************
	// Next contents and read word
	// ****************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			mem_d[i] = mem_q[i];
		end
		// Programming alters a byte; later reads report it
		if (prog_in.write) begin
			mem_d[prog_in.addr] = prog_in.data;
		end
		rdata_d = mem_q[raddr_in];
	end

	// ****************************************
	// Registers; reset models the factory load
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_q[0]  <= customer_reset[23:16];
			mem_q[1]  <= customer_reset[15:8];
			mem_q[2]  <= customer_reset[7:0];
			mem_q[3]  <= `MAKER_ID_RESET;
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			for (int i = 0; i < 4; i++) begin
				mem_q[i] <= mem_d[i];
			end
			rdata_out <= rdata_d;
		end
	end

endmodule

// ### tb/tear_cmds_monitor.sv
`timescale 1ns/1ps

// Pin-level checks of the tear line block
module tear_cmds_monitor (
	// Clock and reset
	input wire logic                    CLK_IN,
	input wire logic                    RST_IN,
	input wire logic                    CE_IN,
	// Host pins and scan timing
	input wire tear_pkg::host_bus_type  HOST_IN,
	input wire tear_pkg::scan_info_type SCAN_IN,
	// Device outputs
	input wire logic [7:0]              DATA_OUT,
	input wire logic                    DATA_OE_OUT,
	input wire logic                    TEAR_SYNC_OUT
);
	// ********
	// Relations
	// ********
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	// Pin edge three to four clocks back: two sync stages, edge detect, output register
	sequence rd_fell4;
		$past(HOST_IN.read_strobe, 4) && !$past(HOST_IN.read_strobe, 3);
	endsequence
	sequence rd_rose4;
		!$past(HOST_IN.read_strobe, 4) && $past(HOST_IN.read_strobe, 3);
	endsequence

	sleep_low_a: assert property (CE_IN && SCAN_IN.sleep_mode |=> !TEAR_SYNC_OUT)
		else $error("tear pin high while asleep");
	tear_start_a: assert property ($rose(TEAR_SYNC_OUT) |-> $past(SCAN_IN.line_start))
		else $error("tear pulse without a line start");
	tear_end_a: assert property ($fell(TEAR_SYNC_OUT) |->
		$past(SCAN_IN.line_start) || $past(SCAN_IN.sleep_mode))
		else $error("tear pulse cut short");
	tear_stand_a: assert property (TEAR_SYNC_OUT && CE_IN && !SCAN_IN.line_start
		&& !SCAN_IN.sleep_mode |=> TEAR_SYNC_OUT) else $error("tear pulse shorter than a line");
	oe_rise_a: assert property ($rose(DATA_OE_OUT) |-> rd_fell4)
		else $error("data enable rose off read timing");
	oe_fall_a: assert property ($fell(DATA_OE_OUT) |-> rd_rose4)
		else $error("data enable fell off read timing");
	oe_cause_a: assert property (DATA_OE_OUT |-> !$past(HOST_IN.read_strobe, 3))
		else $error("data driven outside a read");
	data_hold_a: assert property ($changed(DATA_OUT) |-> rd_fell4)
		else $error("read byte changed off read timing");
	reset_clear_a: assert property ($fell(RST_IN) |->
		!TEAR_SYNC_OUT && !DATA_OE_OUT && DATA_OUT == 8'h00) else $error("outputs not cleared");

	// Main scenarios reached
	cover property ($rose(TEAR_SYNC_OUT));
	cover property ($rose(DATA_OE_OUT));
	cover property (SCAN_IN.sleep_mode && SCAN_IN.line_start);
endmodule

// ### tb/host_model.sv
`timescale 1ns/1ps

// Behavioural host driving the command pins
module host_model (
	// Clock and read data
	input  wire logic              clk_in,
	input  wire logic [7:0]        rdata_in,
	// Host pins
	output tear_pkg::host_bus_type host_out
);
	// ********
	// Bus cycles
	// ********
	// Strobes idle high, parameter select high
	initial host_out = 11'h700;

	// Byte set up with strobe low, taken by the device on the rise
	task automatic write_byte(input logic sel, input logic [7:0] val);
		@(posedge clk_in);
		host_out.command_data_select <= sel;
		host_out.data                <= val;
		host_out.write_strobe        <= 1'b0;
		repeat (4) @(posedge clk_in);
		host_out.write_strobe <= 1'b1;
		repeat (4) @(posedge clk_in);
		// Hold time over: stale byte must not look valid
		host_out.data <= ~val;
	endtask

	// Six clocks low, answer taken at the rising edge of the strobe
	task automatic read_byte(output logic [7:0] val);
		@(posedge clk_in);
		host_out.command_data_select <= 1'b1;
		host_out.read_strobe         <= 1'b0;
		repeat (6) @(posedge clk_in);
		val = rdata_in;
		host_out.read_strobe <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask
endmodule

// ### tb/tear_scanline_cmds_test.sv
`timescale 1ns/1ps
`include "tear_defs.svh"

// Self-checking bench for the tear line and identity commands
module tear_scanline_cmds_test;
	// ********
	// Signals
	// ********
	logic                    clk;
	logic                    rst;
	tear_pkg::host_bus_type  host;
	tear_pkg::scan_info_type scan;
	tear_pkg::id_prog_type   prog;
	logic [7:0]              data_out;
	logic                    oe;
	logic                    tear;
	logic [7:0]              v, bp, tgt, rd;
	logic [7:0]              ids [4];
	int                      errors, num_checks, cycles;

	// Clock enable tied high: freezing is not in scope here
	tear_scanline_cmds u_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .HOST_IN(host),
		.DATA_OUT(data_out), .DATA_OE_OUT(oe), .SCAN_IN(scan), .ID_PROG_IN(prog),
		.TEAR_SYNC_OUT(tear));
	host_model u_host (.clk_in(clk), .rdata_in(data_out), .host_out(host));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_pin(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected tear pin at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] code);
		u_host.write_byte(1'b0, code);
	endtask
	task automatic read_exp(input logic [7:0] exp);
		u_host.read_byte(rd);
		cmp_byte(rd, exp);
	endtask
	// One gate line; pin looked at one clock after the line start
	task automatic scan_line(input logic [7:0] idx, input logic exp);
		@(posedge clk);
		scan.line_start      <= 1'b1;
		scan.gate_line_index <= idx;
		@(posedge clk);
		scan.line_start <= 1'b0;
		@(posedge clk);
		cmp_pin(tear, exp);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ********
	// Tests
	// ********
	initial begin
		rst = 1'b1;
		scan = '0;
		prog = '0;
		v = 8'($urandom(32'h0d0c));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Cleared value, output still disabled
		cmd(`CMD_TEAR_LINE_GET);
		read_exp(`TEAR_LINE_RESET);
		scan_line(8'h02, 1'b0);
		$display("test reset done");
		// Worked example first, then random values and porches
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'h06 : 8'($urandom % 251);
			bp = (i == 0) ? 8'h02 : 8'($urandom % 3);
			tgt = v + 8'h02 - bp;
			scan.back_porch_lines <= bp;
			cmd(`CMD_TEAR_LINE_SET);
			u_host.write_byte(1'b1, v);
			cmd(`CMD_TEAR_LINE_GET);
			read_exp(v);
			scan_line(tgt - 8'h01, 1'b0);
			scan_line(tgt, 1'b1);
			scan_line(tgt + 8'h01, 1'b0);
		end
		$display("test tear line done");
		// Asleep: pin low, commands still served
		scan.sleep_mode <= 1'b1;
		scan_line(tgt, 1'b0);
		cmd(`CMD_TEAR_LINE_SET);
		u_host.write_byte(1'b1, ~v);
		cmd(`CMD_TEAR_LINE_GET);
		read_exp(~v);
		scan.sleep_mode <= 1'b0;
		$display("test sleep done");
		// Reprogram the identity store with random bytes
		for (int a = 0; a < 4; a++) begin
			ids[a] = 8'($urandom);
			@(posedge clk);
			prog <= {1'b1, 2'(a), ids[a]};
			@(posedge clk);
			prog.write <= 1'b0;
		end
		cmd(`CMD_CUSTOMER_ID);
		read_exp(`DUMMY_BYTE);
		for (int a = 0; a < 3; a++) read_exp(ids[a]);
		read_exp(8'h00);
		// Abort after the dummy, then the maker byte
		cmd(`CMD_CUSTOMER_ID);
		read_exp(`DUMMY_BYTE);
		cmd(`CMD_MAKER_ID);
		read_exp(`DUMMY_BYTE);
		read_exp(ids[3]);
		read_exp(8'h00);
		$display("test identity done");
		tally_and_finish();
	end
endmodule

bind tear_scanline_cmds tear_cmds_monitor u_mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.CE_IN(CE_IN), .HOST_IN(HOST_IN), .SCAN_IN(SCAN_IN), .DATA_OUT(DATA_OUT),
	.DATA_OE_OUT(DATA_OE_OUT), .TEAR_SYNC_OUT(TEAR_SYNC_OUT));
